// ---- verilog/ptsl_pkg.sv ----
package ptsl_pkg;

    // Port state codes, one to nine in protocol order.
    typedef enum logic [3:0] {
        PTSL_PS_INITIALIZING = 4'h1,
        PTSL_PS_FAULTY       = 4'h2,
        PTSL_PS_DISABLED     = 4'h3,
        PTSL_PS_LISTENING    = 4'h4,
        PTSL_PS_PRE_MASTER   = 4'h5,
        PTSL_PS_MASTER       = 4'h6,
        PTSL_PS_PASSIVE      = 4'h7,
        PTSL_PS_UNCALIBRATED = 4'h8,
        PTSL_PS_SLAVE        = 4'h9
    } ptsl_port_state_t;

    // Servo condition codes; codes above locked are device specific.
    localparam logic [3:0] SERVO_UNKNOWN   = 4'h0;
    localparam logic [3:0] SERVO_LOCKED    = 4'h1;
    localparam logic [3:0] SERVO_SPECIFIC0 = 4'h2;

    // Accuracy class codes, from 25 ns up to greater than ten seconds.
    typedef enum logic [4:0] {
        PTSL_ACC_25NS      = 5'h00,
        PTSL_ACC_100NS     = 5'h01,
        PTSL_ACC_250NS     = 5'h02,
        PTSL_ACC_1US       = 5'h03,
        PTSL_ACC_2P5US     = 5'h04,
        PTSL_ACC_10US      = 5'h05,
        PTSL_ACC_25US      = 5'h06,
        PTSL_ACC_100US     = 5'h07,
        PTSL_ACC_250US     = 5'h08,
        PTSL_ACC_1MS       = 5'h09,
        PTSL_ACC_2P5MS     = 5'h0A,
        PTSL_ACC_10MS      = 5'h0B,
        PTSL_ACC_25MS      = 5'h0C,
        PTSL_ACC_100MS     = 5'h0D,
        PTSL_ACC_250MS     = 5'h0E,
        PTSL_ACC_1S        = 5'h0F,
        PTSL_ACC_10S       = 5'h10,
        PTSL_ACC_GT10S     = 5'h11,
        PTSL_ACC_ALT       = 5'h12,
        PTSL_ACC_UNKNOWN   = 5'h13,
        PTSL_ACC_RESERVED  = 5'h14
    } ptsl_accuracy_t;

    // Reset values.
    localparam logic              PROTO_ON_RST   = 1'b0;
    localparam ptsl_port_state_t  PORT_STATE_RST = PTSL_PS_INITIALIZING;
    localparam logic [3:0]        SERVO_RST      = SERVO_UNKNOWN;
    localparam logic [63:0]       IDENTITY_RST   = 64'h0000_0000_0000_0000;
    localparam logic [63:0]       OFFSET_RST     = 64'h0000_0000_0000_0000;
    localparam ptsl_accuracy_t    ACCURACY_RST   = PTSL_ACC_UNKNOWN;

endpackage

// ---- verilog/ptsl_fold.sv ----
`timescale 1ns/10ps

// Packs an eight-octet identity so that octet 0 lands in the top byte,
// and folds the live servo condition into the reported code.
module ptsl_fold
(
    input  wire logic [7:0]  id_octet [8],
    input  wire logic        servo_locked,
    input  wire logic [3:0]  servo_detail,
    output logic      [63:0] id_word,
    output logic      [3:0]  servo_code
);

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            id_word[63-8*i -: 8] = id_octet[i];
        end
    end

    // locked wins, otherwise detail or unknown.
    always_comb
    begin
        if (servo_locked)
        begin
            servo_code = ptsl_pkg::SERVO_LOCKED;
        end
        else if (servo_detail >= ptsl_pkg::SERVO_SPECIFIC0)
        begin
            servo_code = servo_detail;
        end
        else
        begin
            servo_code = ptsl_pkg::SERVO_UNKNOWN;
        end
    end

endmodule // ptsl_fold

// ---- verilog/ptsl_latch.sv ----
`timescale 1ns/10ps

module ptsl_latch
(
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    // Switch write port from the feature access logic.
    input  wire logic                       proto_on_wr,
    input  wire logic                       proto_on_wdata,
    output logic                            time_protocol_on,
    // One-cycle snapshot strobe.
    input  wire logic                       snapshot_command,
    // Live values from the protocol engine and servo.
    input  wire ptsl_pkg::ptsl_port_state_t live_port_state,
    input  wire logic                       live_servo_locked,
    input  wire logic [3:0]                 live_servo_detail,
    input  wire logic [63:0]                live_master_offset_ns,
    input  wire logic [7:0]                 live_identity [8],
    input  wire ptsl_pkg::ptsl_accuracy_t   live_accuracy,
    // Read-only views.
    output ptsl_pkg::ptsl_accuracy_t        grandmaster_accuracy_class,
    output ptsl_pkg::ptsl_port_state_t      captured_port_state,
    output logic [3:0]                      captured_servo_state,
    output logic signed [63:0]              captured_master_offset_ns,
    output logic [63:0]                     captured_local_identity
);

    logic                       proto_on_reg;
    logic                       proto_on_next;
    ptsl_pkg::ptsl_port_state_t port_reg;
    ptsl_pkg::ptsl_port_state_t port_next;
    logic [3:0]                 servo_reg;
    logic [3:0]                 servo_next;
    logic [63:0]                offset_reg;
    logic [63:0]                offset_next;
    logic [63:0]                ident_reg;
    logic [63:0]                ident_next;
    ptsl_pkg::ptsl_accuracy_t   acc_reg;
    ptsl_pkg::ptsl_accuracy_t   acc_next;
    logic [63:0]                live_id_word;
    logic [3:0]                 live_servo_code;

    // Identity packing and servo code folding.
    ptsl_fold u_fold
    (
        .id_octet     (live_identity),
        .servo_locked (live_servo_locked),
        .servo_detail (live_servo_detail),
        .id_word      (live_id_word),
        .servo_code   (live_servo_code)
    );

    // Next state: the switch follows writes, snapshots hold otherwise.
    // All captured fields share one strobe, so a read can never mix a
    // field from one snapshot with a field from the next.
    always_comb
    begin
        proto_on_next = proto_on_wr ? proto_on_wdata : proto_on_reg;
        port_next     = port_reg;
        servo_next    = servo_reg;
        offset_next   = offset_reg;
        ident_next    = ident_reg;
        acc_next      = live_accuracy;
        if (snapshot_command)
        begin
            port_next   = live_port_state;
            servo_next  = live_servo_code;
            offset_next = live_master_offset_ns;
            ident_next  = live_id_word;
        end
    end

    // Registers; the accuracy class is registered so the output is clean.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            proto_on_reg <= ptsl_pkg::PROTO_ON_RST;
            port_reg     <= ptsl_pkg::PORT_STATE_RST;
            servo_reg    <= ptsl_pkg::SERVO_RST;
            offset_reg   <= ptsl_pkg::OFFSET_RST;
            ident_reg    <= ptsl_pkg::IDENTITY_RST;
            acc_reg      <= ptsl_pkg::ACCURACY_RST;
        end
        else
        begin
            proto_on_reg <= proto_on_next;
            port_reg     <= port_next;
            servo_reg    <= servo_next;
            offset_reg   <= offset_next;
            ident_reg    <= ident_next;
            acc_reg      <= acc_next;
        end
    end

    // The port code is passed on as the engine gives it; a code outside
    // one to nine would show through, and chk_port_range flags that case.
    // Views come straight from the registers; the accuracy class view follows its live input one cycle late.
    // captured not live, except the accuracy class.
    assign time_protocol_on           = proto_on_reg;
    assign captured_port_state        = port_reg;
    assign captured_servo_state       = servo_reg;
    assign captured_master_offset_ns  = signed'(offset_reg);
    assign captured_local_identity    = ident_reg;
    assign grandmaster_accuracy_class = acc_reg;

    // Named steps of a snapshot: the strobe alone, then the strobe seen
    // together with the live servo condition that it is about to capture.
    sequence snap_s;
        snapshot_command;
    endsequence

    sequence snap_locked_s;
        snapshot_command && live_servo_locked;
    endsequence

    sequence snap_unlocked_s;
        snapshot_command && !live_servo_locked;
    endsequence

    sequence snap_detail_s;
        snapshot_command && !live_servo_locked
            && live_servo_detail >= ptsl_pkg::SERVO_SPECIFIC0;
    endsequence

    sequence snap_vague_s;
        snapshot_command && !live_servo_locked
            && live_servo_detail < ptsl_pkg::SERVO_SPECIFIC0;
    endsequence

    chk_switch_write: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        proto_on_wr |=> time_protocol_on == $past(proto_on_wdata))
        else $error("Switch did not take the written value.");

    chk_switch_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !proto_on_wr |=> $stable(time_protocol_on))
        else $error("Switch changed without a write.");

    chk_snap_port: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_s |=> captured_port_state == $past(live_port_state))
        else $error("Port state not captured on snapshot.");

    chk_port_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !snapshot_command |=> $stable(captured_port_state))
        else $error("Port state view followed live state.");

    chk_port_range: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        captured_port_state >= 4'h1 && captured_port_state <= 4'h9)
        else $error("Port state code out of range.");

    chk_servo_locked: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_locked_s |=> captured_servo_state == 4'h1)
        else $error("Locked servo not reported as locked.");

    chk_servo_unlock: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_unlocked_s |=> captured_servo_state != 4'h1)
        else $error("Unlocked servo reported as locked.");

    chk_offset_cap: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_s |=> captured_master_offset_ns == $past(live_master_offset_ns))
        else $error("Offset not captured on snapshot.");

    chk_ident_msb: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_s |=> captured_local_identity[63:56] == $past(live_identity[0]))
        else $error("Identity octet zero not in top byte.");

    chk_ident_all: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_s |=> captured_local_identity == $past({live_identity[0],
            live_identity[1], live_identity[2], live_identity[3],
            live_identity[4], live_identity[5], live_identity[6],
            live_identity[7]}))
        else $error("Identity octets not packed in order.");

    chk_servo_detail: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_detail_s |=> captured_servo_state == $past(live_servo_detail))
        else $error("Device servo code not reported when unlocked.");

    chk_servo_vague: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        snap_vague_s |=> captured_servo_state == 4'h0)
        else $error("Unlocked servo without detail not reported unknown.");

    chk_acc_follow: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        1'b1 |=> grandmaster_accuracy_class == $past(live_accuracy))
        else $error("Accuracy class did not follow its source.");

    chk_joint_hold: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !snapshot_command |=> $stable(captured_local_identity)
            && $stable(captured_master_offset_ns)
            && $stable(captured_servo_state))
        else $error("Snapshot fields changed apart from a snapshot.");

endmodule // ptsl_latch

// ---- verification/precision_time_status_latch_test.sv ----
`timescale 1ns/10ps

module precision_time_status_latch_test;

    logic                       sys_clk;
    logic                       arst_n;
    logic                       proto_on_wr;
    logic                       proto_on_wdata;
    logic                       time_protocol_on;
    logic                       snapshot_command;
    ptsl_pkg::ptsl_port_state_t live_port_state;
    logic                       live_servo_locked;
    logic [3:0]                 live_servo_detail;
    logic [63:0]                live_master_offset_ns;
    logic [7:0]                 live_identity [8];
    ptsl_pkg::ptsl_accuracy_t   live_accuracy;
    ptsl_pkg::ptsl_accuracy_t   grandmaster_accuracy_class;
    ptsl_pkg::ptsl_port_state_t captured_port_state;
    logic [3:0]                 captured_servo_state;
    logic signed [63:0]         captured_master_offset_ns;
    logic [63:0]                captured_local_identity;
    int                         miscompares;
    int                         compares;
    int                         cycles;

    ptsl_latch dut
    (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .proto_on_wr(proto_on_wr), .proto_on_wdata(proto_on_wdata),
        .time_protocol_on(time_protocol_on),
        .snapshot_command(snapshot_command),
        .live_port_state(live_port_state),
        .live_servo_locked(live_servo_locked),
        .live_servo_detail(live_servo_detail),
        .live_master_offset_ns(live_master_offset_ns),
        .live_identity(live_identity), .live_accuracy(live_accuracy),
        .grandmaster_accuracy_class(grandmaster_accuracy_class),
        .captured_port_state(captured_port_state),
        .captured_servo_state(captured_servo_state),
        .captured_master_offset_ns(captured_master_offset_ns),
        .captured_local_identity(captured_local_identity)
    );

    // A 40 ns clock; inputs move only on its falling edge.
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    // The whole run needs well under a hundred cycles, so 2000 means a hang.
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    // Case inequality keeps an unknown from passing for a match.
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(negedge sys_clk);
    endtask

    // One snapshot pulse, then each captured view is judged in the next cycle.
    task automatic snap(input logic [3:0] ps, input logic lk,
                        input logic [3:0] dt, input logic [63:0] off,
                        input logic [63:0] idw, input logic [3:0] sv);
        step();
        live_port_state = ptsl_pkg::ptsl_port_state_t'(ps);
        live_servo_locked = lk;
        live_servo_detail = dt;
        live_master_offset_ns = off;
        for (int i = 0; i < 8; i++)
            live_identity[i] = idw[63-8*i -: 8];
        snapshot_command = 1'b1;
        step();
        snapshot_command = 1'b0;
        check(64'(captured_port_state), 64'(ps));
        check(64'(captured_servo_state), 64'(sv));
        check(captured_master_offset_ns, off);
        check(captured_local_identity, idw);
    endtask

    task automatic test_switch();
        step();
        proto_on_wr = 1'b1;
        proto_on_wdata = 1'b1;
        step();
        check(64'(time_protocol_on), 64'h1);
        proto_on_wdata = 1'b0;
        step();
        check(64'(time_protocol_on), 64'h0);
        proto_on_wr = 1'b0;
        proto_on_wdata = 1'b1;
        step();
        step();
        check(64'(time_protocol_on), 64'h0);
    endtask

    // Live values move after a snapshot; the views must not follow them.
    task automatic test_hold();
        snap(4'h9, 1'b1, 4'h0, 64'hFFFF_FFFF_FFFF_FC18,
             64'h0011_2233_4455_6677, 4'h1);
        live_port_state = ptsl_pkg::PTSL_PS_FAULTY;
        live_servo_locked = 1'b0;
        live_master_offset_ns = 64'h0000_0000_0000_0005;
        live_identity[0] = 8'hEE;
        step();
        step();
        check(64'(captured_port_state), 64'h9);
        check(64'(captured_servo_state), 64'h1);
        check(captured_master_offset_ns, 64'hFFFF_FFFF_FFFF_FC18);
        check(captured_local_identity, 64'h0011_2233_4455_6677);
    endtask

    task automatic test_codes();
        for (int k = 1; k <= 9; k++)
            snap(4'(k), 1'b0, 4'h0, 64'(k), {8{8'(k)}}, 4'h0);
    endtask

    // Locked wins over detail; detail of 2 and up shows only when unlocked.
    task automatic test_servo();
        snap(4'h6, 1'b1, 4'h5, 64'h0, 64'h8000_0000_0000_0001, 4'h1);
        snap(4'h8, 1'b0, 4'h5, 64'h7, 64'h0102_0304_0506_0708, 4'h5);
        snap(4'h8, 1'b0, 4'hF, 64'h1, 64'h0, 4'hF);
        snap(4'h4, 1'b0, 4'h1, 64'h2, 64'h1, 4'h0);
        snap(4'h4, 1'b0, 4'h0, 64'h3, 64'h2, 4'h0);
    endtask

    // A reset in mid-run clears the switch and the servo, offset and identity views and sets the port view to 1; the port view then stays put.
    task automatic test_reset();
        proto_on_wr = 1'b1;
        proto_on_wdata = 1'b1;
        snap(4'h5, 1'b1, 4'h0, 64'h0000_0000_0000_00FF,
             64'h1111_2222_3333_4444, 4'h1);
        proto_on_wr = 1'b0;
        check(64'(time_protocol_on), 64'h1);
        arst_n = 1'b0;
        step();
        check(64'(time_protocol_on), 64'h0);
        check(64'(captured_port_state), 64'h1);
        check(64'(captured_servo_state), 64'h0);
        check(captured_master_offset_ns, 64'h0);
        check(captured_local_identity, 64'h0);
        arst_n = 1'b1;
        step();
        check(64'(captured_port_state), 64'h1);
    endtask

    task automatic test_accuracy();
        for (int a = 0; a <= 20; a++)
        begin
            live_accuracy = ptsl_pkg::ptsl_accuracy_t'(a);
            step();
            check(64'(grandmaster_accuracy_class), 64'(a));
        end
    endtask

    task automatic report_and_stop();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Reset for two cycles; the views are judged while it is held.
    initial
    begin
        {miscompares, compares, cycles} = '0;
        {arst_n, proto_on_wr, proto_on_wdata, snapshot_command} = '0;
        live_port_state = ptsl_pkg::PTSL_PS_SLAVE;
        {live_servo_locked, live_servo_detail} = 5'h1F;
        live_master_offset_ns = 64'hFFFF_FFFF_FFFF_FFFF;
        for (int i = 0; i < 8; i++)
            live_identity[i] = 8'hA5;
        live_accuracy = ptsl_pkg::PTSL_ACC_UNKNOWN;
        step();
        step();
        check(64'(time_protocol_on), 64'h0);
        check(64'(captured_port_state), 64'h1);
        check(64'(captured_servo_state), 64'h0);
        check(captured_master_offset_ns, 64'h0);
        check(captured_local_identity, 64'h0);
        check(64'(grandmaster_accuracy_class), 64'h13);
        arst_n = 1'b1;
        test_switch();
        test_hold();
        test_codes();
        test_servo();
        test_reset();
        test_accuracy();
        report_and_stop();
    end

endmodule // precision_time_status_latch_test
